// File: logic/static_case_select_eval.sv
// Static control input evaluation: picks the active monitoring case and
// drives the paired safety switch outputs, with APB registers and an irq.
// Assumes channel pins are asynchronous and field_clear_in is on sys_clk_in.
//
// Behaviour
// - Complementary pair: 1/0 is 0, 0/1 is 1
// - Complementary pair equal levels means error
// - One-hot: exactly one channel high, checked
// - One-hot channels map to cases in order
// - One-hot only with more than one input
// - Old case held through switch-on delay
// - Invalid at delay end: outputs off
// - Valid within one second: new case active
// - No valid within second: off, error, restart
// - Sequence monitoring: invalid at end locks error
// - Outputs high when field clear, else low
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
module static_case_select_eval
  import case_sel_pkg::*;
#(
  parameter int NUM_INPUTS  = 2,
  parameter int TICK_CYC    = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_in,
  // APB slave
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [ADDR_W-1:0]     paddr_in,
  input  wire logic [31:0]           pwdata_in,
  output logic      [31:0]           prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  // Static control input channels, index 0 is input A
  input  wire logic [NUM_INPUTS-1:0] input_chan_one_in,
  input  wire logic [NUM_INPUTS-1:0] input_chan_two_in,
  // Protective field state from the scan evaluation
  input  wire logic                  field_clear_in,
  // Safety outputs and status
  output logic                       safety_switch_output_one_out,
  output logic                       safety_switch_output_two_out,
  output logic      [CASE_W-1:0]     active_case_out,
  output logic                       error_out,
  output logic                       irq_out
);

  localparam int  NCH       = 2 * NUM_INPUTS;
  localparam bit  ONEHOT_OK = (NUM_INPUTS > 1);

  if (NUM_INPUTS < 1 || NUM_INPUTS > 4) begin : g_bad_num
    $error("static_case_select_eval: NUM_INPUTS must be 1 to 4");
  end

  // The case field must hold every one-hot case number
  if (NCH >= (1 << CASE_W)) begin : g_bad_case_w
    $error("static_case_select_eval: CASE_W too narrow for NUM_INPUTS");
  end

  if (TICK_CYC < 2) begin : g_bad_tick
    $error("static_case_select_eval: TICK_CYC must be at least 2");
  end

  typedef struct packed {
    fsm_state_t           state;
    logic [NCH-1:0]       pattern;
    logic [CASE_W-1:0]    act_case;
    logic [DELAY_W-1:0]   count;
    logic                 onehot;
    logic                 seqmon;
    logic [DELAY_W-1:0]   delay;
    logic [EV_W-1:0]      irq_stat;
    logic [EV_W-1:0]      irq_mask;
    logic                 out_one;
    logic                 out_two;
    logic                 err;
    logic                 irq;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
  } regs_t;

  regs_t r;
  regs_t n;

  logic [NUM_INPUTS-1:0] one_s;
  logic [NUM_INPUTS-1:0] two_s;
  logic [NCH-1:0]        pat;
  logic                  tick;
  logic                  tick_clr;

  // All channels pass one synchroniser so they are seen as one set
  input_sync #(.W(NCH)) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .async_in   ({input_chan_two_in, input_chan_one_in}),
    .sync_out   (pat)
  );

  assign one_s = pat[NUM_INPUTS-1:0];
  assign two_s = pat[NCH-1:NUM_INPUTS];

  // Restarted on every change in RUN or DELAY so a delay is a whole number of ticks
  tick_divider #(.CYCLES(TICK_CYC)) u_ms (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .clr_in     (tick_clr),
    .tick_out   (tick)
  );

  // Pattern decode
  logic                  dec_valid;
  logic [CASE_W-1:0]     dec_case;
  logic                  comp_valid;
  logic [NUM_INPUTS-1:0] comp_val;
  logic [NCH-1:0]        chan;
  logic [3:0]            ones;
  logic [CASE_W-1:0]     hot_idx;
  logic                  use_onehot;

  always_comb begin
    comp_valid = 1'b1;
    comp_val   = '0;
    chan       = '0;
    ones       = '0;
    hot_idx    = '0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      comp_valid  = comp_valid & (one_s[i] ^ two_s[i]);
      comp_val[i] = two_s[i];
      chan[2*i]   = one_s[i];
      chan[2*i+1] = two_s[i];
    end
    // Channel order A1, A2, B1, B2 gives cases 1 upward
    for (int c = 0; c < NCH; c++) begin
      if (chan[c]) begin
        ones    = ones + 4'h1;
        hot_idx = CASE_W'(c);
      end
    end
    use_onehot = ONEHOT_OK && r.onehot;
    if (use_onehot) begin
      dec_valid = (ones == 4'h1);
      dec_case  = hot_idx + CASE_W'(1);
    end else begin
      dec_valid = comp_valid;
      dec_case  = CASE_W'(comp_val) + CASE_W'(1);
    end
  end

  // Bus and sequencing
  logic                 wr;
  logic                 restart;
  logic [EV_W-1:0]      ev;
  logic [EV_W-1:0]      clr_mask;
  logic                 changed;
  logic                 holds_case;

  always_comb begin
    n         = r;
    ev        = '0;
    tick_clr  = 1'b0;
    changed   = (pat != r.pattern);
    // Zero-wait slave: ready rises in the cycle after setup
    n.pready  = psel_in & ~penable_in;
    n.pslverr = 1'b0;

    // Setup phase: decode address and stage read data for the access phase
    if (psel_in && !penable_in) begin
      n.prdata = '0;
      case (paddr_in)
        OFF_CTRL: begin
          n.prdata[CTRL_ONEHOT] = r.onehot;
          n.prdata[CTRL_SEQMON] = r.seqmon;
        end
        OFF_IRQ_STAT: n.prdata[EV_W-1:0] = r.irq_stat;
        OFF_IRQ_MASK: n.prdata[EV_W-1:0] = r.irq_mask;
        OFF_DELAY:    n.prdata[DELAY_W-1:0] = r.delay;
        OFF_STATUS: begin
          n.prdata[SR_CASE_LSB +: CASE_W] = r.act_case;
          n.prdata[SR_OUT]                = r.out_one;
          n.prdata[SR_ERR]                = r.err;
          n.prdata[SR_STATE_LSB +: $bits(fsm_state_t)] = r.state;
        end
        default: n.pslverr = 1'b1;
      endcase
    end

    // A refused transfer never writes
    wr       = psel_in & penable_in & r.pready & pwrite_in & ~r.pslverr;
    restart  = 1'b0;
    clr_mask = '0;
    if (wr) begin
      case (paddr_in)
        OFF_CTRL: begin
          n.onehot = pwdata_in[CTRL_ONEHOT];
          n.seqmon = pwdata_in[CTRL_SEQMON];
          restart  = pwdata_in[CTRL_RESTART];
        end
        OFF_IRQ_STAT: clr_mask = pwdata_in[EV_W-1:0];
        OFF_IRQ_MASK: n.irq_mask = pwdata_in[EV_W-1:0];
        OFF_DELAY:    n.delay = pwdata_in[DELAY_W-1:0];
        default:      n.delay = r.delay;
      endcase
    end

    case (r.state)
      ST_RUN: begin
        if (changed) begin
          n.pattern = pat;
          n.count   = r.delay;
          n.state   = ST_DELAY;
          tick_clr  = 1'b1;
        end
      end
      ST_DELAY: begin
        if (changed) begin
          // A further change restarts the delay; the old case stays active
          n.pattern = pat;
          n.count   = r.delay;
          tick_clr  = 1'b1;
        end else if (r.count == '0) begin
          if (dec_valid) begin
            n.act_case = dec_case;
            n.state    = ST_RUN;
          end else if (r.seqmon) begin
            n.state = ST_LOCK;
          end else begin
            n.state  = ST_GRACE;
            n.count  = GRACE_MS;
            tick_clr = 1'b1;
          end
        end else if (tick) begin
          n.count = r.count - DELAY_W'(1);
        end
      end
      ST_GRACE: begin
        // No settling here: any valid set ends the window, even a passing one
        n.pattern = pat;
        if (dec_valid) begin
          n.act_case = dec_case;
          n.state    = ST_RUN;
        end else if (r.count == '0) begin
          n.state = ST_LOCK;
        end else if (tick) begin
          n.count = r.count - DELAY_W'(1);
        end
      end
      ST_LOCK: begin
        // Only a restart leaves the latched error
        if (restart) begin
          n.state    = ST_DELAY;
          n.pattern  = pat;
          n.count    = '0;
          n.act_case = '0;
        end
      end
      default: n.state = ST_LOCK;
    endcase

    ev[EV_CASE] = (n.act_case != r.act_case) && (n.act_case != '0);
    ev[EV_OFF]  = (n.state != r.state) && (n.state == ST_GRACE || n.state == ST_LOCK);
    ev[EV_LOCK] = (n.state == ST_LOCK) && (r.state != ST_LOCK);

    // A new event wins over a clear in the same cycle
    n.irq_stat = (r.irq_stat & ~clr_mask) | ev;
    n.irq      = |(n.irq_stat & n.irq_mask);

    // Both outputs come from one decision; the pair differs only on a hardware fault
    n.err      = (n.state == ST_LOCK);
    holds_case = (n.state == ST_RUN || n.state == ST_DELAY) && (n.act_case != '0);
    n.out_one  = field_clear_in & holds_case;
    n.out_two  = field_clear_in & holds_case;
  end

  // Reset lands in DELAY with a zero count, so the first pins are judged at once
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      r          <= '0;
      r.state    <= ST_DELAY;
      r.onehot   <= ONEHOT_RST;
      r.seqmon   <= SEQMON_RST;
      r.delay    <= DELAY_RST;
      r.irq_mask <= MASK_RST;
    end else begin
      r <= n;
    end
  end

  assign prdata_out                   = r.prdata;
  assign pready_out                   = r.pready;
  assign pslverr_out                  = r.pslverr;
  assign safety_switch_output_one_out = r.out_one;
  assign safety_switch_output_two_out = r.out_two;
  assign active_case_out              = r.act_case;
  assign error_out                    = r.err;
  assign irq_out                      = r.irq;

endmodule : static_case_select_eval

// File: logic/case_sel_pkg.sv
// Constants shared by the static case selection block and its helpers.
// Assumes a single 40 MHz system clock and a 32-bit APB register port.
package case_sel_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS         = 1000000;
  // Least time: round up to whole cycles
  localparam int TICK_CYCLES   = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GRACE_S       = 1;
  localparam int GRACE_MS_INT  = GRACE_S * 1000;

  localparam int DELAY_W = 16;
  localparam int CASE_W  = 5;
  localparam int EV_W    = 3;
  localparam int ADDR_W  = 8;

  localparam logic [DELAY_W-1:0] GRACE_MS = DELAY_W'(GRACE_MS_INT);

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_DELAY    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h10;

  // Control bit positions
  localparam int CTRL_ONEHOT  = 0;
  localparam int CTRL_SEQMON  = 1;
  localparam int CTRL_RESTART = 2;

  // Interrupt event bit positions
  localparam int EV_CASE = 0;
  localparam int EV_OFF  = 1;
  localparam int EV_LOCK = 2;

  // Status word field positions
  localparam int SR_CASE_LSB  = 0;
  localparam int SR_OUT       = 8;
  localparam int SR_ERR       = 9;
  localparam int SR_STATE_LSB = 16;

  // Reset values
  localparam logic [DELAY_W-1:0] DELAY_RST = 16'h0000;
  localparam logic [EV_W-1:0]    MASK_RST  = 3'h0;
  localparam logic               ONEHOT_RST = 1'h0;
  localparam logic               SEQMON_RST = 1'h0;

  typedef enum logic [3:0] {
    ST_RUN   = 4'h1,
    ST_DELAY = 4'h2,
    ST_GRACE = 4'h4,
    ST_LOCK  = 4'h8
  } fsm_state_t;

endpackage : case_sel_pkg

// File: logic/input_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to sys_clk_in; output is a flop.
`timescale 1ns/1ps
module input_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  // Pins and result
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
  } sync_regs_t;

  sync_regs_t r;
  sync_regs_t n;

  if (W < 1) begin : g_bad_w
    $error("input_sync: W must be at least 1");
  end

  always_comb begin
    n    = r;
    n.s1 = async_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
    // A bit only moves once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        n.filt[i] = r.s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sync_out = r.filt;

endmodule : input_sync

// File: logic/tick_divider.sv
// Divider giving a one-cycle enable pulse every CYCLES clocks.
// Assumes clr_in is from logic on the same clock; clr restarts the period.
`timescale 1ns/1ps
module tick_divider #(
  parameter int CYCLES = 40000
) (
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  // Control and pulse
  input  wire logic clr_in,
  output logic      tick_out
);

  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          tick;
  } div_regs_t;

  div_regs_t r;
  div_regs_t n;

  if (CYCLES < 2) begin : g_bad_cycles
    $error("tick_divider: CYCLES must be at least 2");
  end

  always_comb begin
    n      = r;
    n.tick = 1'b0;
    if (clr_in) begin
      n.count = '0;
    end else if (r.count == CW'(CYCLES - 1)) begin
      n.count = '0;
      n.tick  = 1'b1;
    end else begin
      n.count = r.count + CW'(1);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick_out = r.tick;

endmodule : tick_divider

// File: dv/case_sel_monitor.sv
// Checker for static case selection: output pair, case timing, error latch.
// Assumes it is bound to the top; CTRL and DELAY are shadowed from APB writes.
`timescale 1ns/1ps
module case_sel_monitor
  import case_sel_pkg::*;
#(
  parameter int NUM_INPUTS = 2,
  parameter int TICK_CYC   = 10
) (
  // Clock, reset and APB
  input wire logic                  sys_clk_in,
  input wire logic                  rst_in,
  input wire logic                  psel_in,
  input wire logic                  penable_in,
  input wire logic                  pwrite_in,
  input wire logic [ADDR_W-1:0]     paddr_in,
  input wire logic [31:0]           pwdata_in,
  input wire logic                  pready_out,
  // Pins and field
  input wire logic [NUM_INPUTS-1:0] input_chan_one_in,
  input wire logic [NUM_INPUTS-1:0] input_chan_two_in,
  input wire logic                  field_clear_in,
  // Results
  input wire logic                  safety_switch_output_one_out,
  input wire logic                  safety_switch_output_two_out,
  input wire logic [CASE_W-1:0]     active_case_out,
  input wire logic                  error_out
);
  logic               wr;
  logic               rs_wr;
  logic               bad;
  logic [DELAY_W-1:0] dly_r;
  logic [2:0]         ctl_r;
  int                 cnt_r;
  int                 lim;
  int                 exp_c;
  assign wr = psel_in && penable_in && pwrite_in && pready_out;
  assign rs_wr = wr && paddr_in == OFF_CTRL && pwdata_in[CTRL_RESTART];
  // Cycles since the last pin change or register write
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      dly_r <= '0;
      ctl_r <= '0;
      cnt_r <= 0;
    end else begin
      if (wr && paddr_in == OFF_DELAY)
        dly_r <= pwdata_in[DELAY_W-1:0];
      if (wr && paddr_in == OFF_CTRL)
        ctl_r <= pwdata_in[2:0];
      if (wr || $changed({input_chan_one_in, input_chan_two_in}))
        cnt_r <= 0;
      else if (cnt_r < 1000000)
        cnt_r <= cnt_r + 1;
    end
  end
  always_comb begin
    lim = int'(dly_r) * TICK_CYC;
    bad = 1'b0;
    exp_c = 1;
    if (ctl_r[CTRL_ONEHOT] && NUM_INPUTS > 1) begin
      bad = $countones({input_chan_two_in, input_chan_one_in}) != 1;
      for (int i = 0; i < NUM_INPUTS; i++) begin
        if (input_chan_one_in[i]) exp_c = 2 * i + 1;
        if (input_chan_two_in[i]) exp_c = 2 * i + 2;
      end
    end else begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        if (input_chan_one_in[i] == input_chan_two_in[i]) bad = 1'b1;
        exp_c = exp_c + (int'(input_chan_two_in[i]) << i);
      end
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  out_pair_a: assert property (safety_switch_output_one_out == safety_switch_output_two_out)
    else $error("safety outputs differ");
  field_off_a: assert property (!field_clear_in |=> !safety_switch_output_one_out)
    else $error("output on with object in field");
  err_off_a: assert property (error_out && $past(error_out) |-> !safety_switch_output_one_out)
    else $error("output on while error latched");
  err_hold_a: assert property (error_out && !rs_wr && !$past(rs_wr) |=> error_out)
    else $error("error cleared without restart");
  case_hold_a: assert property ($changed(active_case_out) && $past(safety_switch_output_one_out)
    |-> cnt_r >= lim + 3)
    else $error("case switched before delay elapsed");
  seq_lock_a: assert property (ctl_r[CTRL_SEQMON] && bad && cnt_r == lim + 16 |-> error_out)
    else $error("no lock on invalid pattern");
  inv_off_a: assert property (bad && cnt_r == lim + 16 |-> !safety_switch_output_one_out)
    else $error("output on with invalid pattern");
  grace_a: assert property (bad && cnt_r == lim + GRACE_MS_INT * TICK_CYC + 40 |-> error_out)
    else $error("no lock after grace window");
  case_val_a: assert property (!bad && !error_out && cnt_r == lim + 16
    |-> active_case_out == CASE_W'(exp_c))
    else $error("active case wrong");
endmodule : case_sel_monitor

bind static_case_select_eval case_sel_monitor #(
  .NUM_INPUTS(NUM_INPUTS),
  .TICK_CYC(TICK_CYC)
) mon_u (.*);

// File: dv/chan_src_model.sv
// Position switch source and downstream safety controller for the bench.
// Assumes the pattern {B2,B1,A2,A1} comes from the bench on the same clock.
`timescale 1ns/1ps
module chan_src_model #(
  parameter int MAX_SKEW = 2
) (
  // Clock and request
  input  wire logic       clk_in,
  input  wire logic [3:0] pat_in,
  input  wire logic       slow_in,
  // Channel pins
  output logic      [1:0] one_out,
  output logic      [1:0] two_out,
  // Output pair, read as two signals
  input  wire logic       out_a_in,
  input  wire logic       out_b_in,
  output logic            safe_stop_out,
  output logic            skew_out
);
  logic [3:0] mid_r = 4'h0;
  logic [3:0] pin_r = 4'h0;
  int         skew_r = 0;
  // Differing outputs are tolerated only for a short, application-chosen time
  always @(posedge clk_in) begin
    skew_r <= (out_a_in != out_b_in) ? skew_r + 1 : 0;
  end
  assign skew_out = skew_r > MAX_SKEW;
  // Slow switches: channel two trails channel one by a cycle
  always @(posedge clk_in) begin
    mid_r <= pat_in;
    pin_r <= slow_in ? ((pat_in & 4'h5) | (mid_r & 4'hA)) : pat_in;
  end
  assign one_out = {pin_r[2], pin_r[0]};
  assign two_out = {pin_r[3], pin_r[1]};
  assign safe_stop_out = !out_a_in || !out_b_in;
endmodule : chan_src_model

// File: dv/static_case_select_eval_tb_top.sv
// Self-checking bench: pins, delay, grace, lock, APB registers and irq.
// Assumes 10 cycles per delay unit so the grace window stays short.
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if (32'(a) !== 32'(e)) begin bad_count++; \
  $display("[ERR] %s exp %0h got %0h", n, 32'(e), 32'(a)); end end
module static_case_select_eval_tb_top;
  import case_sel_pkg::*;
  logic              sys_clk_in = 1'b0;
  logic              rst_in = 1'b1;
  logic              psel_in = 1'b0;
  logic              penable_in = 1'b0;
  logic              pwrite_in = 1'b0;
  logic [ADDR_W-1:0] paddr_in = '0;
  logic [31:0]       pwdata_in = '0;
  logic [31:0]       prdata_out;
  logic [31:0]       rd;
  logic              pready_out, pslverr_out, perr, o1, o2, err, irq, stop;
  logic              fclr = 1'b1;
  logic              slow = 1'b0;
  logic [1:0]        c1, c2;
  logic [3:0]        pat = 4'h5;
  logic [CASE_W-1:0] acase;
  logic              skew;
  int                bad_count = 0;
  int                comparisons = 0;
  int                mode = 0;
  int                m_case = 1;
  int                m_err = 0;
  int                m_grace = 0;
  always #12.5 sys_clk_in = ~sys_clk_in;
  chan_src_model src_u (.clk_in(sys_clk_in), .pat_in(pat), .slow_in(slow), .one_out(c1),
    .two_out(c2), .out_a_in(o1), .out_b_in(o2), .safe_stop_out(stop), .skew_out(skew));
  static_case_select_eval #(.NUM_INPUTS(2), .TICK_CYC(10)) dut_u (.input_chan_one_in(c1),
    .input_chan_two_in(c2), .field_clear_in(fclr), .safety_switch_output_one_out(o1),
    .safety_switch_output_two_out(o2), .active_case_out(acase), .error_out(err),
    .irq_out(irq), .*);
  task automatic end_sim();
    $display("comparisons %0d errors %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int t;
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    for (t = 0; t < 20; t++) begin
      @(posedge sys_clk_in);
      if (pready_out === 1'b1) break;
    end
    rd = prdata_out;
    perr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge sys_clk_in);
    if (t == 20) begin
      bad_count++;
      end_sim();
    end
  endtask : apb
  function automatic int exp_case(int m, logic [3:0] p);
    if (m != 0) begin
      for (int i = 0; i < 4; i++) if (p == 4'(1 << i)) return i + 1;
      return 0;
    end
    if (p[0] == p[1] || p[2] == p[3]) return 0;
    return int'({p[3], p[1]}) + 1;
  endfunction : exp_case
  task automatic apply(input logic [3:0] p, input int n, input logic s = 1'b0);
    int e;
    int ie;
    e = exp_case(mode, p);
    // Slow switches show channel one new and channel two old for a cycle
    ie = s ? exp_case(mode, (p & 4'h5) | (pat & 4'hA)) : 0;
    pat <= p;
    slow <= s;
    repeat (n) @(posedge sys_clk_in);
    // The grace window takes any valid set at once, even a passing one
    if (m_grace != 0 && ie != 0 && m_err == 0) m_case = ie;
    if (e != 0 && m_err == 0) m_case = e;
    m_grace = (e == 0);
    `CHK("skew", 1'b0, skew)
    `CHK("case", m_case, acase)
    `CHK("out", e != 0 && m_err == 0 && fclr, o1)
    `CHK("stop", !(e != 0 && m_err == 0 && fclr), stop)
    `CHK("err", m_err, err)
  endtask : apply
  initial begin
    void'($urandom(32'h0530));
    repeat (12) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    apply(4'h5, 40);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK("status", 32'h0001_0101, rd)
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    `CHK("stat", 32'h3, rd)
    apb(1'b0, OFF_CTRL, 32'h0);
    `CHK("ctrl", 32'h0, rd)
    apb(1'b0, OFF_DELAY, 32'h0);
    `CHK("delay", DELAY_RST, rd)
    apb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped err", 1'b1, perr)
    `CHK("unmapped rd", 32'h0, rd)
    `CHK("irq", 1'b0, irq)
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
    `CHK("irq", 1'b1, irq)
    apb(1'b0, OFF_IRQ_MASK, 32'h0);
    `CHK("mask", 32'h1, rd)
    apb(1'b1, OFF_IRQ_STAT, 32'h1);
    `CHK("irq", 1'b0, irq)
    for (mode = 0; mode < 2; mode++) begin
      apb(1'b1, OFF_CTRL, 32'(mode));
      for (int k = 0; k < 16; k++) begin
        fclr <= ($urandom % 4) != 0;
        apply(4'(k), 24, 1'($urandom));
      end
    end
    mode = 0;
    fclr <= 1'b1;
    slow <= 1'b0;
    apb(1'b1, OFF_CTRL, 32'h0);
    apply(4'h5, 24);
    apb(1'b1, OFF_DELAY, 32'h3);
    pat <= 4'hA;
    repeat (25) @(posedge sys_clk_in);
    `CHK("held", 1, acase)
    `CHK("held on", 1'b1, o1)
    apply(4'hA, 25);
    apb(1'b1, OFF_DELAY, 32'h0);
    apply(4'h0, 20);
    repeat (GRACE_MS_INT * 10 + 60) @(posedge sys_clk_in);
    m_err = 1;
    apply(4'h5, 24);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    `CHK("lock ev", 1'b1, rd[EV_LOCK])
    apb(1'b1, OFF_CTRL, 32'h4);
    m_err = 0;
    apply(4'h5, 24);
    apb(1'b1, OFF_CTRL, 32'h2);
    m_err = 1;
    apply(4'h3, 20);
    apply(4'h5, 20);
    apb(1'b1, OFF_CTRL, 32'h4);
    m_err = 0;
    apply(4'h9, 24);
    end_sim();
  end
endmodule : static_case_select_eval_tb_top
